//--- bench/ibf_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module ibf_host_model (
   // clock and answer
   input wire logic sys_clk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // request
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   // wait limit ran out
   output logic stuck
);
   logic [2:0] bsz = 3'h2;
   initial begin
      {hsel, haddr, htrans, hwrite, hsize, hwdata, stuck} = '0;
   end
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hready !== 1'b1 && n < 64);
      if (hready !== 1'b1) begin
         stuck <= 1'b1;
      end
   endtask
   // one word transfer; released lines show inverted values
   task automatic xfer(input logic wr, input logic [31:0] ad,
                       input logic [31:0] wd, output logic [31:0] rd);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= ad;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= bsz;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      haddr <= ~ad;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
      hwdata <= ~wd;
   endtask
   // single byte write, lane picked by haddr[1:0]
   task automatic wr_byte(input logic [31:0] ad, input logic [7:0] b);
      logic [31:0] d;
      bsz = 3'h0;
      xfer(1'b1, ad, {4{b}}, d);
      bsz = 3'h2;
   endtask
   // lower word first, then upper
   task automatic wr_pair(input logic [7:0] lo, input logic [31:0] v);
      logic [31:0] d;
      xfer(1'b1, {ibf_pkg::ADDR_HI_ZERO, lo, 2'b00}, {16'h0, v[15:0]}, d);
      xfer(1'b1, {ibf_pkg::ADDR_HI_ZERO, lo + 8'h2, 2'b00},
           {16'h0, v[31:16]}, d);
   endtask
endmodule
`default_nettype wire

//--- bench/ibf_regs_checker.sv
`timescale 1ns/1ns
`default_nettype none
module ibf_regs_checker #(
   parameter int unsigned SAMPLE_CYCLES = 8
) (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   // bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // results
   input wire logic signed [31:0] zgyro_out,
   input wire logic out_valid,
   input wire logic sample_tick
);
   // ******
   // helpers
   // ******
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic rd_take;
   logic seen_r;
   logic [31:0] gap_r;
   assign rd_take = hsel && htrans[1] && hready && !hwrite;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gap_r <= 32'h0;
      end else if (ce) begin
         gap_r <= sample_tick ? 32'h1 : gap_r + 32'h1;
      end
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         seen_r <= 1'b0;
      end else if (sample_tick) begin
         seen_r <= 1'b1;
      end
   end
   // ******
   // checks
   // ******
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   a_ready_follows_ce: assert property (hreadyout == ce)
      else $error("ready differs from enable");
   a_rdata_upper_zero: assert property (hrdata[31:16] == 16'h0)
      else $error("read data upper half set");
   a_rdata_holds: assert property (!$stable(hrdata) |-> $past(rd_take))
      else $error("read data moved without a read");
   a_filt_unused_zero: assert property (rd_take && haddr ==
      {ibf_pkg::ADDR_HI_ZERO, ibf_pkg::IDX_AVERAGING_FILTER_CONTROL, 2'b00}
      |=> hrdata[15:3] == 13'h0) else $error("unused control bits set");
   a_unmapped_zero: assert property (rd_take && haddr[31:10] != 22'h0
      |=> hrdata == 32'h0) else $error("unmapped read not zero");
   a_tick_period: assert property (sample_tick && seen_r
      |-> gap_r == SAMPLE_CYCLES) else $error("sample period wrong");
   a_valid_after_tick: assert property (out_valid
      |-> $past(sample_tick, 3)) else $error("result without sample");
   a_out_holds: assert property (!$stable(zgyro_out) |-> out_valid)
      else $error("result moved without valid");
   c_result: cover property (out_valid);
   c_tick: cover property (sample_tick && seen_r);
   c_unmapped: cover property (rd_take && haddr[31:10] != 22'h0);
   c_frozen: cover property (!ce && !hreadyout);
endmodule
bind ibf_regs_top ibf_regs_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) chk (
   .sys_clk, .rst, .ce, .hsel, .haddr, .htrans, .hwrite, .hready,
   .hreadyout, .hresp, .hrdata, .zgyro_out, .out_valid, .sample_tick);
`default_nettype wire

//--- bench/imu_bias_and_filter_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module imu_bias_and_filter_regs_tb;
   localparam int unsigned SC = 8;
   logic sys_clk, rst, hsel, hwrite, hreadyout, hresp, out_valid;
   logic sample_tick, stuck;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, d;
   logic signed [31:0] e, h;
   logic signed [31:0] s_in [4];
   wire logic signed [31:0] s_out [4];
   logic signed [31:0] bias [4];
   logic [ibf_pkg::NV_W-1:0] nv_image_out;
   logic ce, nv_restore;
   logic [ibf_pkg::NV_W-1:0] nv_img;
   logic [7:0] idx [9];
   int fails = 0;
   int tests_run = 0;
   ibf_regs_top #(.SAMPLE_CYCLES(SC)) uut (.sys_clk, .rst, .ce,
      .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hreadyout, .hresp, .hrdata, .zgyro_in(s_in[0]), .xaccel_in(s_in[1]),
      .yaccel_in(s_in[2]), .zaccel_in(s_in[3]), .nv_restore,
      .nv_image_in(nv_img), .nv_image_out, .zgyro_out(s_out[0]),
      .xaccel_out(s_out[1]), .yaccel_out(s_out[2]), .zaccel_out(s_out[3]),
      .out_valid, .sample_tick);
   ibf_host_model host (.sys_clk, .hready(hreadyout), .hrdata, .hsel,
      .haddr, .htrans, .hwrite, .hsize, .hwdata, .stuck);
   // ******
   // helpers
   // ******
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] ad(input logic [7:0] i);
      return {ibf_pkg::ADDR_HI_ZERO, i, 2'b00};
   endfunction
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      host.xfer(1'b0, a, 32'h0, d);
      chk(d, exp);
   endtask
   task automatic wait_ov();
      int n;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (out_valid !== 1'b1 && n < 64);
      if (out_valid !== 1'b1) begin
         fails++;
         close_out();
      end
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (stuck === 1'b1) begin
         fails++;
         close_out();
      end
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      fails++;
      close_out();
   end
   // ******
   // tests
   // ******
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      nv_restore = 1'b0;
      nv_img = '0;
      s_in = '{32'sd100, -32'sd5, 32'h7FFF_FFFF, -32'sd1};
      bias = '{32'hFFFF_FFFE, 32'h0001_0000, 32'h8000_0000, 32'h0000_8000};
      idx = '{ibf_pkg::IDX_ZGYRO_LO, ibf_pkg::IDX_ZGYRO_HI,
         ibf_pkg::IDX_XACCEL_LO, ibf_pkg::IDX_XACCEL_HI,
         ibf_pkg::IDX_YACCEL_LO, ibf_pkg::IDX_YACCEL_HI,
         ibf_pkg::IDX_ZACCEL_LO, ibf_pkg::IDX_BIAS_LAST,
         ibf_pkg::IDX_AVERAGING_FILTER_CONTROL};
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         rd_chk(ad(idx[i]), 32'h0);
      end
      $display("test reset values done");
      for (int i = 0; i < 9; i++) begin
         host.xfer(1'b1, ad(idx[i]), {16'hDEAD, 16'hC3A5 + 16'(i)}, d);
      end
      for (int i = 0; i < 8; i++) begin
         rd_chk(ad(idx[i]), {16'h0, 16'hC3A5 + 16'(i)});
         chk({16'h0, nv_image_out[16*i +: 16]}, 16'hC3A5 + 16'(i));
      end
      rd_chk(ad(ibf_pkg::IDX_AVERAGING_FILTER_CONTROL), 32'h5);
      host.xfer(1'b1, 32'h0000_0400, 32'hFFFF_FFFF, d);
      rd_chk(32'h0000_0400, 32'h0);
      rd_chk(ad(8'h58), 32'h0);
      $display("test read write done");
      host.xfer(1'b1, ad(ibf_pkg::IDX_AVERAGING_FILTER_CONTROL), 32'h0, d);
      for (int c = 0; c < 4; c++) begin
         host.wr_pair(idx[2*c], bias[c]);
      end
      wait_ov();
      wait_ov();
      for (int c = 0; c < 4; c++) begin
         chk(s_out[c], s_in[c] + bias[c]);
      end
      $display("test bias offsets done");
      // freeze right after a result, so no sample is in flight
      @(posedge sys_clk);
      ce <= 1'b0;
      repeat (2 * SC) begin
         @(negedge sys_clk);
         chk({29'h0, hreadyout, sample_tick, out_valid}, 32'h0);
      end
      @(posedge sys_clk);
      ce <= 1'b1;
      $display("test clock enable freeze done");
      wait_ov();
      host.xfer(1'b1, ad(ibf_pkg::IDX_AVERAGING_FILTER_CONTROL), 32'h1, d);
      e = s_in[0] + bias[0];
      h = e >>> 1;
      wait_ov();
      chk(s_out[0], h >>> 1);
      wait_ov();
      chk(s_out[0], (h + e) >>> 1);
      wait_ov();
      chk(s_out[0], e);
      rd_chk(ad(ibf_pkg::IDX_STATUS), 32'h0000_0102);
      $display("test filter window done");
      host.wr_byte(ad(ibf_pkg::IDX_AVERAGING_FILTER_CONTROL), 8'h04);
      host.wr_byte(ad(ibf_pkg::IDX_AVERAGING_FILTER_CONTROL) | 32'h1, 8'h00);
      rd_chk(ad(ibf_pkg::IDX_AVERAGING_FILTER_CONTROL), 32'h4);
      rd_chk(ad(ibf_pkg::IDX_STATUS), 32'h0000_0010);
      $display("test byte writes done");
      @(posedge sys_clk);
      for (int i = 0; i < 9; i++) begin
         nv_img[16*i +: 16] <= 16'hA501 + 16'(i);
      end
      nv_restore <= 1'b1;
      @(posedge sys_clk);
      nv_restore <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         rd_chk(ad(idx[i]), (i < 8) ? 32'hA501 + 32'(i) : 32'h1);
      end
      $display("test backup restore done");
      close_out();
   end
endmodule
`default_nettype wire

//--- hw/ibf_avg_filter.sv
`timescale 1ns/1ns
`default_nettype none
module ibf_avg_filter #(
   parameter int unsigned MAX_EXP = 7
) (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   // sample path
   ibf_filt_if.flt f
);
   localparam int unsigned DEPTH = 1 << MAX_EXP;
   localparam int unsigned AW = MAX_EXP;
   localparam int unsigned SW = 32 + MAX_EXP;

   logic [2:0] exp_r;
   logic chg;
   logic signed [31:0] st_d [0:2];
   logic st_v [0:2];
   logic [1:0] full;
   logic [AW:0] n;

   assign chg = f.tap_exp != exp_r;
   assign n = (AW + 1)'(1) << exp_r;
   assign st_d[0] = f.in_data;
   assign st_v[0] = f.in_valid;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         exp_r <= 3'h0;
      end else if (ce) begin
         exp_r <= f.tap_exp;
      end
   end

   // ************************************************************
   // two cascaded running averages
   // ************************************************************
   genvar s;
   for (s = 0; s < 2; s++) begin : g_stage
      logic signed [31:0] mem [0:DEPTH-1];
      logic [AW-1:0] wp_r;
      logic [AW:0] fill_r;
      logic signed [SW-1:0] sum_r;
      logic signed [SW-1:0] sum_nxt;
      logic signed [31:0] old;
      logic signed [31:0] avg_r;
      logic v_r;

      // oldest of the last n samples, zero while filling
      assign old = (fill_r == n) ? mem[wp_r - AW'(n)] : 32'sh0;
      assign sum_nxt = sum_r + SW'(st_d[s]) - SW'(old);
      assign full[s] = fill_r == n;

      always_ff @(posedge sys_clk) begin
         if (ce && st_v[s] && !chg) begin
            mem[wp_r] <= st_d[s];
         end
      end

      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            wp_r <= '0;
            fill_r <= '0;
            sum_r <= '0;
            avg_r <= 32'sh0;
            v_r <= 1'b0;
         end else if (ce) begin
            v_r <= st_v[s] & ~chg;
            if (chg) begin
               fill_r <= '0;
               sum_r <= '0;
            end else if (st_v[s]) begin
               wp_r <= wp_r + AW'(1);
               if (fill_r != n) begin
                  fill_r <= fill_r + (AW + 1)'(1);
               end
               sum_r <= sum_nxt;
               avg_r <= 32'(sum_nxt >>> exp_r);
            end
         end
      end
      assign st_d[s+1] = avg_r;
      assign st_v[s+1] = v_r;
   end

   assign f.out_data = st_d[2];
   assign f.out_valid = st_v[2];
   assign f.settled = &full;
endmodule
`default_nettype wire

//--- hw/ibf_filt_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ibf_filt_if;
   logic in_valid;
   logic signed [31:0] in_data;
   logic [2:0] tap_exp;
   logic out_valid;
   logic signed [31:0] out_data;
   logic settled;
   modport src(output in_valid, in_data, tap_exp,
               input out_valid, out_data, settled);
   modport flt(input in_valid, in_data, tap_exp,
               output out_valid, out_data, settled);
endinterface
`default_nettype wire

//--- hw/ibf_pkg.sv
package ibf_pkg;
   // ************************************************************
   // register indices (byte address is four times the index)
   // ************************************************************
   localparam logic [7:0] IDX_BIAS_FIRST = 8'h48;
   localparam logic [7:0] IDX_ZGYRO_LO = 8'h48;
   localparam logic [7:0] IDX_ZGYRO_HI = 8'h4A;
   localparam logic [7:0] IDX_XACCEL_LO = 8'h4C;
   localparam logic [7:0] IDX_XACCEL_HI = 8'h4E;
   localparam logic [7:0] IDX_YACCEL_LO = 8'h50;
   localparam logic [7:0] IDX_YACCEL_HI = 8'h52;
   localparam logic [7:0] IDX_ZACCEL_LO = 8'h54;
   localparam logic [7:0] IDX_BIAS_LAST = 8'h56;
   localparam logic [7:0] IDX_AVERAGING_FILTER_CONTROL = 8'h5C;
   localparam logic [7:0] IDX_STATUS = 8'h5E;
   localparam logic [21:0] ADDR_HI_ZERO = 22'h000000;
   // ************************************************************
   // storage slots
   // ************************************************************
   localparam int unsigned NUM_CH = 4;
   localparam int unsigned NUM_REG = 9;
   localparam logic [3:0] SLOT_FILT = 4'h8;
   localparam logic [3:0] SLOT_STAT = 4'h9;
   localparam logic [3:0] SLOT_NONE = 4'hF;
   localparam int unsigned NV_W = 16 * NUM_REG;
   // ************************************************************
   // fields and reset values
   // ************************************************************
   localparam logic [15:0] BIAS_RESET = 16'h0000;
   localparam logic [15:0] FILT_RESET = 16'h0000;
   localparam int unsigned TAP_EXP_LSB = 0;
   localparam int unsigned TAP_EXP_W = 3;
   localparam int unsigned STAT_SETTLED_BIT = 8;
   localparam logic [2:0] HSIZE_BYTE = 3'h0;
   localparam logic [2:0] HSIZE_HALF = 3'h1;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned SAMPLE_HZ = 2000;
   localparam int unsigned SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
   localparam int unsigned MAX_TAP_EXP = 7;
endpackage

//--- hw/ibf_regs_top.sv
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - z gyro bias words form 32-bit signed offset
// - x accel bias words form 32-bit offset
// - y accel bias pair applied like x
// - z accel bias pair applied like x
// - upper word is most significant half
// - bias words 16-bit, rw, zero reset, backed
// - control bits 2:0 give N=2^B, rest unused
// - two cascaded averaging stages, triangular window
// - filter control 16-bit, rw, zero, backed
// - output delayed about N samples
// - correction chain runs at 2000 Hz
module ibf_regs_top #(
   parameter int unsigned SAMPLE_CYCLES = ibf_pkg::SAMPLE_CYCLES,
   parameter int unsigned MAX_TAP_EXP = ibf_pkg::MAX_TAP_EXP
) (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // factory-corrected samples
   input wire logic signed [31:0] zgyro_in,
   input wire logic signed [31:0] xaccel_in,
   input wire logic signed [31:0] yaccel_in,
   input wire logic signed [31:0] zaccel_in,
   // backup storage
   input wire logic nv_restore,
   input wire logic [ibf_pkg::NV_W-1:0] nv_image_in,
   output logic [ibf_pkg::NV_W-1:0] nv_image_out,
   // filtered results
   output logic signed [31:0] zgyro_out,
   output logic signed [31:0] xaccel_out,
   output logic signed [31:0] yaccel_out,
   output logic signed [31:0] zaccel_out,
   output logic out_valid,
   output logic sample_tick
);
   localparam int unsigned NREG = ibf_pkg::NUM_REG;
   localparam int unsigned NCH = ibf_pkg::NUM_CH;

   // ************************************************************
   // elaboration checks
   // ************************************************************
   if (SAMPLE_CYCLES < 4) begin : g_bad_rate
      $error("SAMPLE_CYCLES must be at least 4");
   end
   if (MAX_TAP_EXP < 1 || MAX_TAP_EXP > 7) begin : g_bad_exp
      $error("MAX_TAP_EXP must lie in 1..7");
   end
   // storage layout must match the backup image and channel pairs
   if (ibf_pkg::NV_W != 16 * NREG) begin : g_bad_image
      $error("backup image width does not match register count");
   end
   if (ibf_pkg::SLOT_FILT != 4'(NREG - 1)) begin : g_bad_filt_slot
      $error("filter control must be the last storage slot");
   end
   if (2 * NCH + 1 != NREG) begin : g_bad_pairs
      $error("each channel needs a lower and an upper word");
   end

   // ************************************************************
   // address decode
   // ************************************************************
   function automatic logic [3:0] slot_of(input logic [31:0] a);
      logic [7:0] idx;
      idx = a[9:2];
      slot_of = ibf_pkg::SLOT_NONE;
      if (a[31:10] == ibf_pkg::ADDR_HI_ZERO) begin
         if (idx >= ibf_pkg::IDX_BIAS_FIRST &&
             idx <= ibf_pkg::IDX_BIAS_LAST && !idx[0]) begin
            slot_of = 4'((idx - ibf_pkg::IDX_BIAS_FIRST) >> 1);
         end else if (idx == ibf_pkg::IDX_AVERAGING_FILTER_CONTROL) begin
            slot_of = ibf_pkg::SLOT_FILT;
         end else if (idx == ibf_pkg::IDX_STATUS) begin
            slot_of = ibf_pkg::SLOT_STAT;
         end
      end
   endfunction

   // byte lanes of the low half-word touched by a transfer
   function automatic logic [1:0] lanes_of(input logic [2:0] sz,
                                           input logic [1:0] lo);
      if (sz == ibf_pkg::HSIZE_BYTE) begin
         lanes_of = {lo == 2'h1, lo == 2'h0};
      end else if (sz == ibf_pkg::HSIZE_HALF) begin
         lanes_of = {2{lo[1] == 1'b0}};
      end else begin
         lanes_of = 2'h3;
      end
   endfunction

   // ************************************************************
   // bus slave, address and data phase
   // ************************************************************
   logic addr_ok;
   logic dp_wr_r;
   logic [3:0] dp_slot_r;
   logic [1:0] dp_be_r;
   logic [31:0] hrdata_r;
   logic [15:0] regs_r [0:NREG-1];
   logic [15:0] regs_nxt [0:NREG-1];
   logic [15:0] status;
   logic [2:0] tap_exp;
   logic [NCH-1:0] settled;

   // wait states only while the block is frozen
   assign hreadyout = ce;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;
   assign addr_ok = hsel & htrans[1] & hready;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dp_wr_r <= 1'b0;
         dp_slot_r <= ibf_pkg::SLOT_NONE;
         dp_be_r <= 2'h0;
      end else if (ce) begin
         dp_wr_r <= addr_ok & hwrite;
         dp_slot_r <= slot_of(haddr);
         dp_be_r <= lanes_of(hsize, haddr[1:0]);
      end
   end

   function automatic logic [15:0] read_of(input logic [3:0] sl);
      read_of = 16'h0000;
      if (sl == ibf_pkg::SLOT_STAT) begin
         read_of = status;
      end else if (sl < 4'(NREG)) begin
         read_of = regs_nxt[sl];
      end
   endfunction

   // read data sees a write finishing in the same cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hrdata_r <= 32'h00000000;
      end else if (ce && addr_ok && !hwrite) begin
         hrdata_r <= {16'h0000, read_of(slot_of(haddr))};
      end
   end

   // ************************************************************
   // register storage with backup image
   // ************************************************************
   always_comb begin
      for (int i = 0; i < NREG; i++) begin
         regs_nxt[i] = nv_restore ? nv_image_in[16*i +: 16] : regs_r[i];
         if (dp_wr_r && dp_slot_r == 4'(i)) begin
            // byte writes let low and high halves land apart
            if (dp_be_r[0]) begin
               regs_nxt[i][7:0] = hwdata[7:0];
            end
            if (dp_be_r[1]) begin
               regs_nxt[i][15:8] = hwdata[15:8];
            end
         end
      end
      regs_nxt[ibf_pkg::SLOT_FILT][15:ibf_pkg::TAP_EXP_W] = '0;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NREG - 1; i++) begin
            regs_r[i] <= ibf_pkg::BIAS_RESET;
         end
         regs_r[ibf_pkg::SLOT_FILT] <= ibf_pkg::FILT_RESET;
      end else if (ce) begin
         for (int i = 0; i < NREG; i++) begin
            regs_r[i] <= regs_nxt[i];
         end
      end
   end

   genvar g;
   for (g = 0; g < NREG; g++) begin : g_nv
      assign nv_image_out[16*g +: 16] = regs_r[g];
   end

   // ************************************************************
   // tap exponent and status
   // ************************************************************
   always_comb begin
      tap_exp = regs_r[ibf_pkg::SLOT_FILT][ibf_pkg::TAP_EXP_LSB +:
                                           ibf_pkg::TAP_EXP_W];
      if (tap_exp > 3'(MAX_TAP_EXP)) begin
         tap_exp = 3'(MAX_TAP_EXP);
      end
   end

   always_comb begin
      status = 16'h0000;
      status[7:0] = 8'h01 << tap_exp;
      status[ibf_pkg::STAT_SETTLED_BIT] = &settled;
   end

   // ************************************************************
   // sample rate tick
   // ************************************************************
   logic [31:0] tick_cnt_r;
   logic tick_r;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tick_cnt_r <= 32'h00000000;
         tick_r <= 1'b0;
      end else if (ce) begin
         tick_r <= tick_cnt_r == 32'(SAMPLE_CYCLES - 1);
         if (tick_cnt_r == 32'(SAMPLE_CYCLES - 1)) begin
            tick_cnt_r <= 32'h00000000;
         end else begin
            tick_cnt_r <= tick_cnt_r + 32'h00000001;
         end
      end
   end
   assign sample_tick = tick_r;

   // ************************************************************
   // bias correction and filtering per channel
   // ************************************************************
   logic signed [31:0] raw [0:NCH-1];
   logic signed [31:0] filt_q [0:NCH-1];
   logic [NCH-1:0] fvalid;

   assign raw[0] = zgyro_in;
   assign raw[1] = xaccel_in;
   assign raw[2] = yaccel_in;
   assign raw[3] = zaccel_in;

   for (g = 0; g < NCH; g++) begin : g_ch
      ibf_filt_if fif();
      logic signed [31:0] offset;
      logic signed [31:0] corr_r;
      logic corr_v_r;

      // upper word is the high half of the offset
      assign offset = {regs_r[2*g+1], regs_r[2*g]};

      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            corr_r <= 32'sh0;
            corr_v_r <= 1'b0;
         end else if (ce) begin
            corr_v_r <= tick_r;
            if (tick_r) begin
               corr_r <= raw[g] + offset;
            end
         end
      end

      assign fif.in_valid = corr_v_r;
      assign fif.in_data = corr_r;
      assign fif.tap_exp = tap_exp;
      assign filt_q[g] = fif.out_data;
      assign fvalid[g] = fif.out_valid;
      assign settled[g] = fif.settled;

      ibf_avg_filter #(
         .MAX_EXP(MAX_TAP_EXP)
      ) u_filt (
         .sys_clk(sys_clk),
         .rst(rst),
         .ce(ce),
         .f(fif.flt)
      );
   end

   assign zgyro_out = filt_q[0];
   assign xaccel_out = filt_q[1];
   assign yaccel_out = filt_q[2];
   assign zaccel_out = filt_q[3];
   assign out_valid = &fvalid;
endmodule
`default_nettype wire
